// ### logic/brs_pkg.sv
// Package for the break and reset status register bank.
// Assumes an Avalon-MM slave with 32-bit data and byte addressing.
package brs_pkg;

  // Printed offsets are not all multiples of four: they are indices,
  // and the byte address is four times the index.
  localparam logic [15:0] BREAK_STATUS_IDX   = 16'hfe00;
  localparam logic [15:0] RESET_CAUSE_IDX    = 16'hfe01;
  localparam logic [15:0] BREAK_FLAG_CTL_IDX = 16'hfe03;
  localparam logic [15:0] IRQ_STATUS_IDX     = 16'hfe08;
  localparam logic [15:0] IRQ_MASK_IDX       = 16'hfe09;

  localparam int ADDR_W = 18;

  // Break status register fields
  localparam int BREAK_EXIT_BIT = 1;
  // Break flag control register fields
  localparam int BREAK_FLAG_CLEAR_EN_BIT = 7;
  // Reset cause register fields
  localparam int CAUSE_BROWNOUT_BIT = 1;
  localparam int CAUSE_MONITOR_BIT  = 2;
  localparam int CAUSE_BAD_FETCH_BIT = 3;
  localparam int CAUSE_BAD_OPCODE_BIT = 4;
  localparam int CAUSE_WATCHDOG_BIT = 5;
  localparam int CAUSE_PIN_BIT      = 6;
  localparam int CAUSE_POWER_ON_BIT = 7;
  // Interrupt status/mask fields
  localparam int IRQ_BREAK_EXIT_BIT = 0;
  localparam int IRQ_RESET_SEEN_BIT = 1;

  localparam logic [7:0] BREAK_STATUS_RST   = 8'h00;
  localparam logic [7:0] RESET_CAUSE_RST    = 8'h00;
  localparam logic [7:0] BREAK_FLAG_CTL_RST = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RST     = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST       = 8'h00;
  localparam logic [7:0] BREAK_STATUS_MASK  = 8'h02;
  localparam logic [7:0] BREAK_FLAG_CTL_MASK = 8'h80;
  localparam logic [7:0] IRQ_MASK_BITS      = 8'h03;

  // Reset source pulses, one bit per cause
  typedef struct packed {
    logic powerOn;
    logic pin;
    logic watchdog;
    logic badOpcode;
    logic badFetch;
    logic monitorEntry;
    logic brownout;
  } brs_reset_src_s;

  typedef enum logic [1:0] {
    BRS_IDLE,
    BRS_ANSWER
  } brs_bus_e;

endpackage

// ### logic/brs_regs.sv
// Break status, reset cause and break flag control registers with an
// interrupt status/mask pair, on an Avalon-MM slave.
// Assumes resetSrc pulses and breakExitEvt come from logic on clk.
//
// Summary of operation
// - Five registers sit at fixed word indices, all reachable by ordinary software access.
// - Break interrupt ending stop or wait sets the break-exit flag.
// - Writing 0 clears the break-exit flag; any reset clears it too.
// - Reading the reset cause register returns its value, then clears every flag.
// - Power-on reset sets its flag and clears all other cause flags.
// - Other resets set only their own flag, leaving the rest.
// - External reset pin assertion sets the pin reset flag.
// - Watchdog timeout sets the watchdog reset flag.
// - Illegal opcode decode sets the bad-opcode reset flag.
// - Only opcode fetch from illegal address sets bad-fetch flag, not data accesses.
// - Monitor entry with zero reset vector after power-on sets monitor flag.
// - Low-voltage inhibit reset sets the brownout reset flag.
// - Clear-enable bit is read/write; when 0 break-state flag clears are blocked.
// - Flag cleared in break with clearing enabled stays cleared after break.
// - Two-step clears stay protected in break; second step after break clears.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module brs_regs
  import brs_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [ADDR_W-1:0]   avsAddress,
  input  wire logic                avsRead,
  input  wire logic                avsWrite,
  input  wire logic [31:0]         avsWritedata,
  input  wire logic [3:0]          avsByteenable,
  output logic [31:0]              avsReaddata,
  output logic                     avsWaitrequest,
  output logic [1:0]               avsResponse,
  input  wire brs_reset_src_s      resetSrc,
  input  wire logic                breakExitEvt,
  input  wire logic                breakState,
  input  wire logic                flagClearReq,
  output logic                     flagClearAllow,
  output logic                     irq
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
  endfunction

  brs_bus_e    busState;
  brs_bus_e    next_busState;
  logic [31:0] next_avsReaddata;
  logic [1:0]  next_avsResponse;

  logic [7:0] breakStatus;
  logic [7:0] resetCause;
  logic [7:0] breakFlagCtl;
  logic [7:0] irqStatus;
  logic [7:0] irqMask;
  logic [7:0] next_breakStatus;
  logic [7:0] next_resetCause;
  logic [7:0] next_breakFlagCtl;
  logic [7:0] next_irqStatus;
  logic [7:0] next_irqMask;

  logic       take;
  logic       wrLow;
  logic       anyReset;

  // One-cycle answer: the request is taken in IDLE, waitrequest drops in ANSWER
  assign take           = (busState == BRS_IDLE) && (avsRead || avsWrite);
  assign avsWaitrequest = (busState != BRS_ANSWER);
  assign wrLow          = avsWrite && avsByteenable[0];
  assign anyReset       = |resetSrc;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_busState     = busState;
    next_avsReaddata  = avsReaddata;
    next_avsResponse  = avsResponse;
    next_breakStatus  = breakStatus;
    next_resetCause   = resetCause;
    next_breakFlagCtl = breakFlagCtl;
    next_irqStatus    = irqStatus;
    next_irqMask      = irqMask;

    case (busState)
      BRS_IDLE: begin
        if (take) begin
          next_busState    = BRS_ANSWER;
          next_avsReaddata = 32'h0000_0000;
          next_avsResponse = 2'h0;
          if (hit(avsAddress, BREAK_STATUS_IDX)) begin
            next_avsReaddata[7:0] = breakStatus & BREAK_STATUS_MASK;
            if (wrLow && !avsWritedata[BREAK_EXIT_BIT])
              next_breakStatus[BREAK_EXIT_BIT] = 1'b0;
          end else if (hit(avsAddress, RESET_CAUSE_IDX)) begin
            next_avsReaddata[7:0] = resetCause;
            if (avsRead)
              next_resetCause = 8'h00;
          end else if (hit(avsAddress, BREAK_FLAG_CTL_IDX)) begin
            next_avsReaddata[7:0] = breakFlagCtl & BREAK_FLAG_CTL_MASK;
            if (wrLow)
              next_breakFlagCtl = avsWritedata[7:0] & BREAK_FLAG_CTL_MASK;
          end else if (hit(avsAddress, IRQ_STATUS_IDX)) begin
            next_avsReaddata[7:0] = irqStatus;
            if (wrLow)
              next_irqStatus = irqStatus & ~(avsWritedata[7:0] & IRQ_MASK_BITS);
          end else if (hit(avsAddress, IRQ_MASK_IDX)) begin
            next_avsReaddata[7:0] = irqMask;
            if (wrLow)
              next_irqMask = avsWritedata[7:0] & IRQ_MASK_BITS;
          end else begin
            next_avsResponse = 2'h2;
          end
        end
      end
      BRS_ANSWER: begin
        next_busState = BRS_IDLE;
      end
      default: begin
        next_busState = BRS_IDLE;
      end
    endcase

    // Hardware events win over a same-cycle software clear
    if (breakExitEvt)
      next_breakStatus[BREAK_EXIT_BIT] = 1'b1;
    if (anyReset)
      next_breakStatus[BREAK_EXIT_BIT] = 1'b0;

    if (resetSrc.powerOn) begin
      next_resetCause = 8'h00;
      next_resetCause[CAUSE_POWER_ON_BIT] = 1'b1;
    end
    // Other causes only add their own bit
    if (resetSrc.pin)
      next_resetCause[CAUSE_PIN_BIT] = 1'b1;
    if (resetSrc.watchdog)
      next_resetCause[CAUSE_WATCHDOG_BIT] = 1'b1;
    if (resetSrc.badOpcode)
      next_resetCause[CAUSE_BAD_OPCODE_BIT] = 1'b1;
    if (resetSrc.badFetch)
      next_resetCause[CAUSE_BAD_FETCH_BIT] = 1'b1;
    if (resetSrc.monitorEntry)
      next_resetCause[CAUSE_MONITOR_BIT] = 1'b1;
    if (resetSrc.brownout)
      next_resetCause[CAUSE_BROWNOUT_BIT] = 1'b1;

    if (breakExitEvt)
      next_irqStatus[IRQ_BREAK_EXIT_BIT] = 1'b1;
    if (anyReset)
      next_irqStatus[IRQ_RESET_SEEN_BIT] = 1'b1;
  end

  // ---------------------------------------------------------------
  // Break-state flag clear gate
  // ---------------------------------------------------------------
  // Peripherals apply each clearing step only when allowed; a first step
  // done before break still needs an allowed second step, and a cleared
  // flag is never restored here.
  assign flagClearAllow = flagClearReq &&
                          (!breakState || breakFlagCtl[BREAK_FLAG_CLEAR_EN_BIT]);

  assign irq = |(irqStatus & irqMask);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      busState     <= BRS_IDLE;
      avsReaddata  <= 32'h0000_0000;
      avsResponse  <= 2'h0;
      breakStatus  <= BREAK_STATUS_RST;
      resetCause   <= RESET_CAUSE_RST;
      breakFlagCtl <= BREAK_FLAG_CTL_RST;
      irqStatus    <= IRQ_STATUS_RST;
      irqMask      <= IRQ_MASK_RST;
    end else begin
      busState     <= next_busState;
      avsReaddata  <= next_avsReaddata;
      avsResponse  <= next_avsResponse;
      breakStatus  <= next_breakStatus;
      resetCause   <= next_resetCause;
      breakFlagCtl <= next_breakFlagCtl;
      irqStatus    <= next_irqStatus;
      irqMask      <= next_irqMask;
    end
  end

endmodule

`default_nettype wire

// ### tb/brs_regs_sva.sv
// Concurrent checks on the break and reset status register bank ports.
// Assumes it is bound onto brs_regs and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module brs_regs_sva
  import brs_pkg::*;
(
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] avsAddress,
  input wire logic              avsRead,
  input wire logic              avsWrite,
  input wire logic [31:0]       avsReaddata,
  input wire logic              avsWaitrequest,
  input wire logic [1:0]        avsResponse,
  input wire brs_reset_src_s    resetSrc,
  input wire logic              breakExitEvt,
  input wire logic              breakState,
  input wire logic              flagClearReq,
  input wire logic              flagClearAllow
);
  // ----------------
  // Checks
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic        take;
  logic        mapped;
  logic [15:0] idx;
  assign take   = (avsRead || avsWrite) && avsWaitrequest;
  assign idx    = avsAddress[17:2];
  assign mapped = idx inside {16'hfe00, 16'hfe01, 16'hfe03, 16'hfe08, 16'hfe09};
  sequence s_po;
    resetSrc == 7'h40 ##1 resetSrc == 7'h0 && take && avsRead && idx == RESET_CAUSE_IDX;
  endsequence
  sequence s_bx;
    breakExitEvt && resetSrc == 7'h0 ##1 take && avsRead && idx == BREAK_STATUS_IDX;
  endsequence
  sequence s_rc2;
    take && avsRead && idx == RESET_CAUSE_IDX && resetSrc == 7'h0 ##1
      (resetSrc == 7'h0)[*2] ##1 resetSrc == 7'h0 && take && avsRead && idx == RESET_CAUSE_IDX;
  endsequence
  a_wait_one: assert property (!avsWaitrequest |=> avsWaitrequest) else $error("wait low too long");
  a_take_answer: assert property (take |=> !avsWaitrequest) else $error("no answer");
  a_mapped_ok: assert property (take && mapped |=> avsResponse == 2'b00) else $error("bad resp");
  a_unmapped_err: assert property (take && !mapped |=> avsResponse == 2'b10) else $error("resp");
  a_power_on: assert property (s_po |=> avsReaddata[7:0] == 8'h80) else $error("power-on");
  a_break_set: assert property (s_bx |=> avsReaddata[1]) else $error("break flag not set");
  a_cause_clear: assert property (s_rc2 |=> avsReaddata[7:0] == 8'h00) else $error("not clr");
  a_high_zero: assert property (avsReaddata[31:8] == 24'h0) else $error("upper bits set");
  a_allow_open: assert property (!breakState |-> flagClearAllow == flagClearReq) else $error("gate");
  a_allow_req: assert property (flagClearAllow |-> flagClearReq) else $error("allow without req");
endmodule
bind brs_regs brs_regs_sva chk (.clk(clk), .srst(srst), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsReaddata(avsReaddata),
  .avsWaitrequest(avsWaitrequest), .avsResponse(avsResponse), .resetSrc(resetSrc),
  .breakExitEvt(breakExitEvt), .breakState(breakState), .flagClearReq(flagClearReq),
  .flagClearAllow(flagClearAllow));
`default_nettype wire

// ### tb/break_and_reset_status_regs_tb.sv
// Self-checking bench for brs_regs.
// Assumes the checker file is compiled alongside; bench is the bus master.
`timescale 1ns/1ps
`default_nettype none
module break_and_reset_status_regs_tb
  import brs_pkg::*;
;
  // ----------------
  // Stimulus
  // ----------------
  logic              clk, srst, avsRead, avsWrite, avsWaitrequest, breakExitEvt;
  logic              breakState, flagClearReq, flagClearAllow, irq;
  logic [ADDR_W-1:0] avsAddress;
  logic [31:0]       avsWritedata, avsReaddata;
  logic [1:0]        avsResponse;
  logic [7:0]        q;
  brs_reset_src_s    resetSrc;
  int                num_errors, num_checks;
  brs_regs DUT (.clk(clk), .srst(srst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(4'hf),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .avsResponse(avsResponse),
    .resetSrc(resetSrc), .breakExitEvt(breakExitEvt), .breakState(breakState),
    .flagClearReq(flagClearReq), .flagClearAllow(flagClearAllow), .irq(irq));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    avsAddress <= {idx, 2'b00};
    avsRead <= !w;
    avsWrite <= w;
    avsWritedata <= {24'h0, d};
    // Look at waitrequest mid-cycle, then take the answer at the next rising edge
    do begin
      @(negedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("unexpected at %0t: bus answer timed out", $time);
    end
    @(posedge clk);
    q = avsReaddata[7:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk8(q, exp);
  endtask
  task automatic evt(input logic [6:0] v, input logic b);
    resetSrc <= brs_reset_src_s'(v);
    breakExitEvt <= b;
    @(posedge clk);
    resetSrc <= '0;
    breakExitEvt <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial begin
    {srst, avsRead, avsWrite, breakExitEvt, breakState, flagClearReq} = 6'b100000;
    {avsAddress, avsWritedata, resetSrc} = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(BREAK_STATUS_IDX, 8'h00);
    rd(RESET_CAUSE_IDX, 8'h00);
    rd(16'hfe02, 8'h00);
    chk8({6'h0, avsResponse}, 8'h02);
    for (int i = 0; i < 7; i++) begin
      evt(7'h01 << i, 1'b0);
      rd(RESET_CAUSE_IDX, 8'h02 << i);
      rd(RESET_CAUSE_IDX, 8'h00);
    end
    evt(7'h20, 1'b0);
    evt(7'h10, 1'b0);
    rd(RESET_CAUSE_IDX, 8'h60);
    evt(7'h20, 1'b0);
    evt(7'h40, 1'b0);
    rd(RESET_CAUSE_IDX, 8'h80);
    bus(IRQ_STATUS_IDX, 1'b1, 8'h03);
    bus(IRQ_MASK_IDX, 1'b1, 8'h01);
    evt(7'h00, 1'b1);
    rd(BREAK_STATUS_IDX, 8'h02);
    chkb(irq, 1'b1);
    bus(IRQ_MASK_IDX, 1'b1, 8'h00);
    chkb(irq, 1'b0);
    bus(IRQ_MASK_IDX, 1'b1, 8'h01);
    bus(IRQ_STATUS_IDX, 1'b1, 8'h01);
    chkb(irq, 1'b0);
    bus(BREAK_STATUS_IDX, 1'b1, 8'hff);
    rd(BREAK_STATUS_IDX, 8'h02);
    bus(BREAK_STATUS_IDX, 1'b1, 8'h00);
    rd(BREAK_STATUS_IDX, 8'h00);
    evt(7'h00, 1'b1);
    evt(7'h04, 1'b0);
    rd(BREAK_STATUS_IDX, 8'h00);
    bus(BREAK_FLAG_CTL_IDX, 1'b1, 8'hff);
    rd(BREAK_FLAG_CTL_IDX, 8'h80);
    breakState <= 1'b1;
    flagClearReq <= 1'b1;
    @(posedge clk);
    chkb(flagClearAllow, 1'b1);
    bus(BREAK_FLAG_CTL_IDX, 1'b1, 8'h00);
    chkb(flagClearAllow, 1'b0);
    breakState <= 1'b0;
    @(posedge clk);
    chkb(flagClearAllow, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
